// File: bench/ecl_eeprom_model.sv
`timescale 1ns/100ps
`default_nettype none
module ecl_eeprom_model #(
	parameter int AW = 4
) (
	input  wire logic present,
	input  wire logic ee_cs,
	input  wire logic ee_sk,
	input  wire logic ee_di,
	output logic      ee_do
);
	logic [15:0]   mem [0:(1<<AW)-1];
	logic [AW-1:0] addr;
	logic [2:0]    cmd;
	logic          dout = 1'b1;
	int            cnt;

	// ==========================================================
	// serial read answer
	// ==========================================================
	// released or absent memory leaves only the pull-up
	assign ee_do = (present && ee_cs) ? dout : 1'b1;

	always @(negedge ee_cs) begin
		cnt = 0;
		dout = 1'b1;
	end

	// data changes just after the rising serial clock
	always @(posedge ee_sk) begin
		if (ee_cs) begin
			if (cnt < 3)
				cmd = {cmd[1:0], ee_di};
			else if (cnt < 3 + AW)
				addr = {addr[AW-2:0], ee_di};
			if (cmd != 3'b110)
				dout = 1'b1;
			else if (cnt == 2 + AW)
				dout = 1'b0;
			else if (cnt > 2 + AW && cnt <= 18 + AW)
				dout = mem[addr][18 + AW - cnt];
			else
				dout = 1'b1;
			cnt++;
		end
	end
endmodule : ecl_eeprom_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic              clk = 1'b0;
	logic              link_clk = 1'b0;
	logic              rst;
	logic              reload_req;
	logic              present;
	logic              pci_retry;
	ecl_pkg::ecl_cfg_t cfg;
	ecl_pkg::ecl_cfg_t exp;
	logic              ee_cs;
	logic              ee_sk;
	logic              ee_di;
	logic              ee_do;
	logic [15:0]       img [$];
	int                fails;
	int                total_checks;

	ecl_loader i_dut (
		.clk       (clk),
		.rst       (rst),
		.link_clk  (link_clk),
		.reload_req(reload_req),
		.pci_retry (pci_retry),
		.cfg       (cfg),
		.ee_cs     (ee_cs),
		.ee_sk     (ee_sk),
		.ee_di     (ee_di),
		.ee_do     (ee_do)
	);

	ecl_eeprom_model #(.AW(4)) i_mem (
		.present(present),
		.ee_cs  (ee_cs),
		.ee_sk  (ee_sk),
		.ee_di  (ee_di),
		.ee_do  (ee_do)
	);

	always #5 clk = ~clk;
	// 80 ns, offset so its edges never meet the core clock
	initial begin
		#3.3;
		forever #40 link_clk = ~link_clk;
	end

	// ==========================================================
	// helpers
	// ==========================================================
	function automatic logic [15:0] zw(input int m, input logic [6:0] o,
		input logic [7:0] d);
		return {(m != 0), o, d};
	endfunction : zw

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		total_checks++;
		if (got !== want) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk

	task automatic chk_cfg(input ecl_pkg::ecl_cfg_t e);
		chk(cfg.local_config_control, e.local_config_control);
		chk(cfg.multipurpose_io_config, e.multipurpose_io_config);
		chk(cfg.local_bus_timing_first, e.local_bus_timing_first);
		chk(cfg.local_bus_timing_second, e.local_bus_timing_second);
		chk(cfg.global_interrupt_source, e.global_interrupt_source);
		chk({16'h0, cfg.vendor_id}, {16'h0, e.vendor_id});
		chk({16'h0, cfg.subsys_vendor_id}, {16'h0, e.subsys_vendor_id});
	endtask : chk_cfg

	// unused words read as all ones to expose stray reads
	task automatic load_image();
		for (int i = 0; i < 16; i++)
			i_mem.mem[i] = (i < img.size()) ? img[i] : 16'hffff;
	endtask : load_image

	task automatic wait_load();
		int n;
		n = 0;
		while (pci_retry !== 1'b1 && n < 10) begin
			@(posedge clk);
			#1 n++;
		end
		chk({31'h0, pci_retry}, 32'h1);
		n = 0;
		while (pci_retry !== 1'b0 && n < 40000) begin
			@(posedge clk);
			#1 n++;
		end
		chk({31'h0, pci_retry}, 32'h0);
	endtask : wait_load

	// held long enough for the link domain to see it too
	task automatic do_reset();
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (30) @(posedge clk);
		#1 rst = 1'b0;
		wait_load();
	endtask : do_reset

	task automatic reload();
		@(posedge clk);
		#1 reload_req = 1'b1;
		@(posedge clk);
		#1 reload_req = 1'b0;
		wait_load();
	endtask : reload

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// ==========================================================
	// tests
	// ==========================================================
	initial begin
		rst = 1'b1;
		reload_req = 1'b0;
		present = 1'b1;
		fails = 0;
		total_checks = 0;
		// every writable offset, never ending: runs off the memory
		img = {16'h9610, zw(1, 7'h00, 8'hfc), zw(1, 7'h04, 8'h11),
			zw(1, 7'h05, 8'h22), zw(1, 7'h06, 8'hff), zw(1, 7'h07, 8'hff),
			zw(1, 7'h08, 8'ha1), zw(1, 7'h09, 8'hb2), zw(1, 7'h0a, 8'hc3),
			zw(1, 7'h0b, 8'hd4), zw(1, 7'h0c, 8'h55), zw(1, 7'h0d, 8'h66),
			zw(1, 7'h0e, 8'hf0), zw(1, 7'h0f, 8'hc7), zw(1, 7'h1e, 8'hf3),
			zw(1, 7'h1f, 8'h7f)};
		load_image();
		do_reset();
		exp = ecl_pkg::CFG_RESET;
		exp.local_config_control = 32'h5000_00fc;
		exp.multipurpose_io_config = 32'he43f_2211;
		exp.local_bus_timing_first = 32'hd4c3_b2a1;
		exp.local_bus_timing_second = 32'hc7f0_6655;
		exp.global_interrupt_source = 32'h7ff3_0000;
		chk_cfg(exp);
		$display("test overrun done");

		// reserved select last, so a stray low-bit decode would show
		img = {16'h961c, zw(0, 7'h05, 8'h5a), zw(1, 7'h00, 8'h34),
			zw(1, 7'h01, 8'h12), zw(1, 7'h02, 8'h78), zw(1, 7'h03, 8'h56),
			zw(0, 7'h07, 8'h99)};
		load_image();
		reload();
		exp = ecl_pkg::CFG_RESET;
		exp.local_config_control = 32'h1000_0000;
		exp.multipurpose_io_config = 32'h0000_5a00;
		exp.vendor_id = 16'h1234;
		exp.subsys_vendor_id = 16'h5678;
		chk_cfg(exp);
		$display("test zones done");

		img = {16'h9518, zw(0, 7'h04, 8'h77), zw(0, 7'h00, 8'h12)};
		load_image();
		do_reset();
		chk_cfg(ecl_pkg::CFG_RESET);
		$display("test signature done");

		img = {16'h9608, zw(0, 7'h01, 8'hab), zw(0, 7'h04, 8'h77)};
		load_image();
		reload();
		exp = ecl_pkg::CFG_RESET;
		exp.local_config_control = 32'h1000_0000;
		exp.vendor_id = {8'hab, ecl_pkg::VEND_RESET[7:0]};
		chk_cfg(exp);
		$display("test absent zone done");

		present = 1'b0;
		reload();
		chk_cfg(ecl_pkg::CFG_RESET);
		$display("test no memory done");
		test_done();
	end

	initial begin
		#(90000 * 10);
		fails++;
		$display("watchdog expired");
		test_done();
	end
endmodule : testbench
`default_nettype wire

// File: core/ecl_link.sv
`timescale 1ns/100ps
`default_nettype none
module ecl_link (
	input  wire logic              link_clk,
	input  wire logic              rst,
	input  wire logic              req_tog,
	input  wire ecl_pkg::ecl_req_t req,
	output logic                   ack_tog,
	output ecl_pkg::ecl_rsp_t      rsp,
	output logic                   ee_cs,
	output logic                   ee_sk,
	output logic                   ee_di,
	input  wire logic              ee_do
);

	typedef enum logic [4:0] {
		L_IDLE = 5'b00001,
		L_CMD  = 5'b00010,
		L_ADDR = 5'b00100,
		L_DATA = 5'b01000,
		L_DONE = 5'b10000
	} ecl_lstate_t;

	ecl_lstate_t lstate;
	logic        rst_m;
	logic        rst_l;
	logic        req_m;
	logic        req_s;
	logic        do_m;
	logic        do_s;
	logic [2:0]  hcnt;
	logic [4:0]  bcnt;
	logic [12:0] sh;
	logic        detect;
	logic        bit_end;
	logic        half_end;
	logic [4:0]  next_bcnt;

	// ==========================================================
	// crossings into the link domain
	// ==========================================================
	always_ff @(posedge link_clk) begin
		rst_m <= rst;
		rst_l <= rst_m;
	end

	always_ff @(posedge link_clk) begin
		req_m <= req_tog;
		req_s <= req_m;
		do_m  <= ee_do;
		do_s  <= do_m;
	end

	assign half_end  = (hcnt == ecl_pkg::LINK_HALF);
	assign bit_end   = half_end && ee_sk;
	assign next_bcnt = bcnt + 5'h01;

	// ==========================================================
	// read sequence: command, address, dummy zero, 16 data bits
	// ==========================================================
	always_ff @(posedge link_clk) begin
		if (rst_l) begin
			lstate  <= L_IDLE;
			ee_cs   <= 1'b0;
			ee_sk   <= 1'b0;
			ee_di   <= 1'b0;
			hcnt    <= 3'h0;
			bcnt    <= 5'h00;
			sh      <= 13'h0000;
			detect  <= 1'b0;
			ack_tog <= 1'b0;
			rsp     <= '0;
		end else begin
			hcnt <= (lstate == L_IDLE || half_end) ? 3'h0 : hcnt + 3'h1;
			if (half_end && lstate != L_IDLE && lstate != L_DONE)
				ee_sk <= ~ee_sk;
			if (bit_end) begin
				sh    <= {sh[11:0], 1'b0};
				ee_di <= sh[11];
				bcnt  <= next_bcnt;
			end
			unique case (lstate)
				L_IDLE: if (req_s != ack_tog) begin
					lstate <= L_CMD;
					ee_cs  <= 1'b1;
					detect <= (req.width == 4'h0);
					sh     <= {ecl_pkg::CMD_READ, 10'(req.addr <<
						(ecl_pkg::ADDR_BITS_MAX - req.width))};
					ee_di  <= ecl_pkg::CMD_READ[2];
					bcnt   <= 5'h00;
					rsp    <= '0;
				end
				L_CMD: if (bit_end && bcnt == ecl_pkg::CMD_LAST) begin
					lstate <= L_ADDR;
					bcnt   <= 5'h00;
				end
				// size detection: zeros go out until the dummy zero shows
				L_ADDR: if (bit_end) begin
					if (detect ? !do_s : (next_bcnt[3:0] == req.width)) begin
						lstate    <= L_DATA;
						bcnt      <= 5'h00;
						rsp.width <= next_bcnt[3:0];
					end else if (next_bcnt[3:0] == ecl_pkg::ADDR_BITS_MAX) begin
						lstate   <= L_DONE;
						rsp.fail <= 1'b1;
					end
				end
				L_DATA: if (bit_end) begin
					rsp.data <= {rsp.data[14:0], do_s};
					if (bcnt == ecl_pkg::DATA_LAST)
						lstate <= L_DONE;
				end
				L_DONE: begin
					ee_cs   <= 1'b0;
					ee_sk   <= 1'b0;
					ee_di   <= 1'b0;
					ack_tog <= req_s;
					lstate  <= L_IDLE;
				end
				default: lstate <= L_IDLE;
			endcase
		end
	end

	a_link_idle_quiet: assert property (
		@(posedge link_clk) disable iff (rst_l)
		(lstate == L_IDLE) |-> (!ee_sk && !ee_cs))
		else $error("serial clock or select active while idle");

endmodule : ecl_link
`default_nettype wire

// File: core/ecl_loader.sv
`timescale 1ns/100ps
`default_nettype none
module ecl_loader (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         link_clk,
	input  wire logic         reload_req,
	output logic              pci_retry,
	output ecl_pkg::ecl_cfg_t cfg,
	output logic              ee_cs,
	output logic              ee_sk,
	output logic              ee_di,
	input  wire logic         ee_do
);

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_WAIT  = 4'b0100,
		ST_PARSE = 4'b1000
	} ecl_state_t;

	ecl_state_t        state;
	logic              start_pending;
	logic [2:0]        zone;
	logic [4:0]        pending;
	logic [9:0]        addr;
	logic [3:0]        width;
	logic [15:0]       word;
	logic              req_tog;
	logic              ack_tog;
	logic              ack_m;
	logic              ack_s;
	ecl_pkg::ecl_req_t req;
	ecl_pkg::ecl_rsp_t rsp;

	logic              begin_load;
	logic              over;
	logic              done;
	logic              sig_ok;
	logic              more;
	logic [6:0]        off;
	logic [4:0]        hdr_pending;
	logic [2:0]        next_zone;
	logic              go_next;
	logic              advance;

	// ==========================================================
	// helpers
	// ==========================================================
	// number of the lowest-numbered zone still flagged, zero if none
	function automatic logic [2:0] pick_zone(input logic [4:0] p);
		logic [2:0] z;
		z = 3'h0;
		for (int i = 0; i < 5; i++)
			if (z == 3'h0 && p[4 - i])
				z = 3'(i + 1);
		return z;
	endfunction : pick_zone

	function automatic logic [4:0] drop_zone(input logic [4:0] p,
		input logic [2:0] z);
		logic [4:0] r;
		r = p;
		if (z != 3'h0)
			r[3'h5 - z] = 1'b0;
		return r;
	endfunction : drop_zone

	// true when the address lies at or beyond the detected size
	function automatic logic beyond(input logic [9:0] a,
		input logic [3:0] w);
		logic [9:0] hi;
		hi = a >> w;
		return (w != 4'h0) && (hi != 10'h000);
	endfunction : beyond

	// writes outside the listed offsets are dropped here, which keeps
	// stray image bytes from touching unrelated state
	function automatic ecl_pkg::ecl_cfg_t apply_local(
		input ecl_pkg::ecl_cfg_t c,
		input logic [6:0]        o,
		input logic [7:0]        d);
		ecl_pkg::ecl_cfg_t r;
		r = c;
		unique case (o)
			ecl_pkg::OFF_CTRL0: r.local_config_control[7:2] = d[7:2];
			ecl_pkg::OFF_MPIO0: r.multipurpose_io_config[7:0] = d;
			ecl_pkg::OFF_MPIO1: r.multipurpose_io_config[15:8] = d;
			ecl_pkg::OFF_MPIO2: r.multipurpose_io_config[21:16] = d[5:0];
			ecl_pkg::OFF_MPIO3: begin
				r.multipurpose_io_config[26]    = d[2];
				r.multipurpose_io_config[31:29] = d[7:5];
			end
			ecl_pkg::OFF_TIMA0: r.local_bus_timing_first[7:0] = d;
			ecl_pkg::OFF_TIMA1: r.local_bus_timing_first[15:8] = d;
			ecl_pkg::OFF_TIMA2: r.local_bus_timing_first[23:16] = d;
			ecl_pkg::OFF_TIMA3: r.local_bus_timing_first[31:24] = d;
			ecl_pkg::OFF_TIMB0: r.local_bus_timing_second[7:0] = d;
			ecl_pkg::OFF_TIMB1: r.local_bus_timing_second[15:8] = d;
			ecl_pkg::OFF_TIMB2: r.local_bus_timing_second[23:20] = d[7:4];
			ecl_pkg::OFF_TIMB3: begin
				r.local_bus_timing_second[26:24] = d[2:0];
				r.local_bus_timing_second[31:30] = d[7:6];
			end
			ecl_pkg::OFF_IMSK2: begin
				r.global_interrupt_source[17:16] = d[1:0];
				r.global_interrupt_source[23:20] = d[7:4];
			end
			ecl_pkg::OFF_IMSK3: r.global_interrupt_source[30:24] = d[6:0];
			default: r = c;
		endcase
		return r;
	endfunction : apply_local

	function automatic ecl_pkg::ecl_cfg_t apply_id(
		input ecl_pkg::ecl_cfg_t c,
		input logic [6:0]        o,
		input logic [7:0]        d);
		ecl_pkg::ecl_cfg_t r;
		r = c;
		unique case (o)
			ecl_pkg::ID_VEND_LO: r.vendor_id[7:0] = d;
			ecl_pkg::ID_VEND_HI: r.vendor_id[15:8] = d;
			ecl_pkg::ID_SUBV_LO: r.subsys_vendor_id[7:0] = d;
			ecl_pkg::ID_SUBV_HI: r.subsys_vendor_id[15:8] = d;
			default: r = c;
		endcase
		return r;
	endfunction : apply_id

	// ==========================================================
	// decode of the current word
	// ==========================================================
	assign begin_load  = (state == ST_IDLE) && (start_pending || reload_req);
	assign over        = beyond(addr, width);
	assign done        = (ack_s == req_tog);
	assign sig_ok      = (word[ecl_pkg::HDR_SIG_MSB:ecl_pkg::HDR_SIG_LSB]
		== ecl_pkg::SIGNATURE);
	assign more        = word[ecl_pkg::WORD_MORE_BIT];
	assign off         = word[ecl_pkg::WORD_OFF_MSB:ecl_pkg::WORD_OFF_LSB];
	assign hdr_pending = (zone == 3'h0) ? word[4:0] : pending;
	assign next_zone   = pick_zone(hdr_pending);
	// zones past the identification zone are not walked here
	assign go_next     = (next_zone == 3'h1) || (next_zone == 3'h2);
	assign advance     = (zone == 3'h0) ? (sig_ok && go_next)
		: (more || go_next);
	assign pci_retry   = (state != ST_IDLE);

	// ==========================================================
	// sequencing
	// ==========================================================
	always_ff @(posedge clk) begin
		if (rst) begin
			state         <= ST_IDLE;
			start_pending <= 1'b1;
		end else begin
			if (begin_load)
				start_pending <= 1'b0;
			unique case (state)
				ST_IDLE:  if (begin_load) state <= ST_FETCH;
				ST_FETCH: state <= over ? ST_IDLE : ST_WAIT;
				ST_WAIT:  if (done) state <= rsp.fail ? ST_IDLE : ST_PARSE;
				ST_PARSE: state <= advance ? ST_FETCH : ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			zone    <= 3'h0;
			pending <= 5'h00;
			addr    <= 10'h000;
			width   <= 4'h0;
			word    <= 16'h0000;
		end else if (begin_load) begin
			zone    <= 3'h0;
			pending <= 5'h00;
			addr    <= 10'h000;
			width   <= 4'h0;
		end else if (state == ST_WAIT && done && !rsp.fail) begin
			word <= rsp.data;
			if (width == 4'h0)
				width <= rsp.width;
		end else if (state == ST_PARSE && advance) begin
			addr <= addr + 10'h001;
			if (zone == 3'h0 || !more) begin
				zone    <= next_zone;
				pending <= drop_zone(hdr_pending, next_zone);
			end
		end
	end

	// ==========================================================
	// applied configuration
	// ==========================================================
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg <= ecl_pkg::CFG_RESET;
		end else if (begin_load) begin
			cfg <= ecl_pkg::CFG_RESET;
		end else if (state == ST_FETCH && over) begin
			cfg.local_config_control[ecl_pkg::CTRL_OVRUN_BIT] <= 1'b1;
		end else if (state == ST_PARSE) begin
			unique case (zone)
				3'h0: if (sig_ok)
					cfg.local_config_control[ecl_pkg::CTRL_VALID_BIT] <= 1'b1;
				3'h1: cfg <= apply_local(cfg, off, word[7:0]);
				3'h2: cfg <= apply_id(cfg, off, word[7:0]);
				default: cfg <= cfg;
			endcase
		end
	end

	// ==========================================================
	// word handshake with the link domain
	// ==========================================================
	// request fields stay still from the toggle until the answer
	always_ff @(posedge clk) begin
		if (rst) begin
			req_tog <= 1'b0;
			req     <= '0;
		end else if (state == ST_FETCH && !over) begin
			req_tog <= ~req_tog;
			req     <= '{addr, width};
		end
	end

	always_ff @(posedge clk) begin
		ack_m <= ack_tog;
		ack_s <= ack_m;
	end

	ecl_link u_link (
		.link_clk (link_clk),
		.rst      (rst),
		.req_tog  (req_tog),
		.req      (req),
		.ack_tog  (ack_tog),
		.rsp      (rsp),
		.ee_cs    (ee_cs),
		.ee_sk    (ee_sk),
		.ee_di    (ee_di),
		.ee_do    (ee_do)
	);

	// ==========================================================
	// checks
	// ==========================================================
	a_reset_starts_load: assert property (
		@(posedge clk) disable iff (rst)
		$past(rst) |-> ##1 pci_retry)
		else $error("no load after reset release");

	a_reload_busy: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_IDLE && reload_req) |=> (state == ST_FETCH)
			##1 pci_retry)
		else $error("reload request not taken");

	a_sig_valid: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_PARSE && zone == 3'h0 && sig_ok)
			|=> cfg.local_config_control[ecl_pkg::CTRL_VALID_BIT])
		else $error("valid flag not set on good signature");

	a_sig_bad_stop: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_PARSE && zone == 3'h0 && !sig_ok)
			|=> (state == ST_IDLE)
			&& !cfg.local_config_control[ecl_pkg::CTRL_VALID_BIT]
			&& cfg.multipurpose_io_config == ecl_pkg::MPIO_RESET)
		else $error("bad signature did not stop clean");

	a_overrun_flag: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_FETCH && over) |=> (state == ST_IDLE)
			&& cfg.local_config_control[ecl_pkg::CTRL_OVRUN_BIT]
			&& $stable(req_tog))
		else $error("overrun not flagged");

	a_zone_next: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_PARSE && zone == 3'h1 && !more && pending[3])
			|=> (zone == 3'h2) && (state == ST_FETCH)
			&& (addr == $past(addr) + 10'h001))
		else $error("zone 2 not entered after zone 1");

	a_zone_more: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_PARSE && zone == 3'h1 && more)
			|=> (zone == 3'h1) ##1 (state == ST_WAIT
			|| cfg.local_config_control[ecl_pkg::CTRL_OVRUN_BIT]))
		else $error("zone 1 continuation lost");

	a_local_ctrl: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_PARSE && zone == 3'h1 && off == ecl_pkg::OFF_CTRL0)
			|=> cfg.local_config_control[7:2] == $past(word[7:2]))
		else $error("control byte not applied");

	a_id_vendor: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_PARSE && zone == 3'h2 && off == ecl_pkg::ID_VEND_HI)
			|=> cfg.vendor_id[15:8] == $past(word[7:0]))
		else $error("vendor id high byte not applied");

	a_id_ignore: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_PARSE && zone == 3'h2 && off > ecl_pkg::ID_SUBV_HI)
			|=> $stable(cfg.vendor_id) && $stable(cfg.subsys_vendor_id))
		else $error("reserved select wrote a register");

	a_zone2_end: assert property (
		@(posedge clk) disable iff (rst)
		(state == ST_PARSE && zone == 3'h2 && !more && pending == 5'h00)
			|=> !pci_retry)
		else $error("load did not end after zone 2");

endmodule : ecl_loader
`default_nettype wire

// File: core/ecl_pkg.sv
package ecl_pkg;

	// ==========================================================
	// image layout
	// ==========================================================
	localparam logic [7:0] SIGNATURE      = 8'h96;
	localparam int         HDR_SIG_MSB    = 15;
	localparam int         HDR_SIG_LSB    = 8;
	localparam int         WORD_MORE_BIT  = 15;
	localparam int         WORD_OFF_MSB   = 14;
	localparam int         WORD_OFF_LSB   = 8;
	localparam int         CTRL_VALID_BIT = 28;
	localparam int         CTRL_OVRUN_BIT = 30;

	// ==========================================================
	// local register byte offsets
	// ==========================================================
	localparam logic [6:0] OFF_CTRL0 = 7'h00;
	localparam logic [6:0] OFF_MPIO0 = 7'h04;
	localparam logic [6:0] OFF_MPIO1 = 7'h05;
	localparam logic [6:0] OFF_MPIO2 = 7'h06;
	localparam logic [6:0] OFF_MPIO3 = 7'h07;
	localparam logic [6:0] OFF_TIMA0 = 7'h08;
	localparam logic [6:0] OFF_TIMA1 = 7'h09;
	localparam logic [6:0] OFF_TIMA2 = 7'h0a;
	localparam logic [6:0] OFF_TIMA3 = 7'h0b;
	localparam logic [6:0] OFF_TIMB0 = 7'h0c;
	localparam logic [6:0] OFF_TIMB1 = 7'h0d;
	localparam logic [6:0] OFF_TIMB2 = 7'h0e;
	localparam logic [6:0] OFF_TIMB3 = 7'h0f;
	localparam logic [6:0] OFF_IMSK2 = 7'h1e;
	localparam logic [6:0] OFF_IMSK3 = 7'h1f;

	// identification selects
	localparam logic [6:0] ID_VEND_LO = 7'h00;
	localparam logic [6:0] ID_VEND_HI = 7'h01;
	localparam logic [6:0] ID_SUBV_LO = 7'h02;
	localparam logic [6:0] ID_SUBV_HI = 7'h03;

	// ==========================================================
	// values after reset (plain defaults)
	// ==========================================================
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MPIO_RESET = 32'h0000_0000;
	localparam logic [31:0] TIMA_RESET = 32'h0000_0000;
	localparam logic [31:0] TIMB_RESET = 32'h0000_0000;
	localparam logic [31:0] IMSK_RESET = 32'h0000_0000;
	// identity defaults: arbitrary values
	localparam logic [15:0] VEND_RESET = 16'h0a5a;
	localparam logic [15:0] SUBV_RESET = 16'h0a5a;

	// ==========================================================
	// serial link
	// ==========================================================
	localparam logic [2:0] CMD_READ      = 3'b110;
	localparam logic [3:0] ADDR_BITS_MAX = 4'ha;
	localparam logic [4:0] CMD_LAST      = 5'h02;
	localparam logic [4:0] DATA_LAST     = 5'h0f;
	localparam logic [2:0] LINK_HALF     = 3'h3;

	typedef struct packed {
		logic [31:0] local_config_control;
		logic [31:0] multipurpose_io_config;
		logic [31:0] local_bus_timing_first;
		logic [31:0] local_bus_timing_second;
		logic [31:0] global_interrupt_source;
		logic [15:0] vendor_id;
		logic [15:0] subsys_vendor_id;
	} ecl_cfg_t;

	localparam ecl_cfg_t CFG_RESET = '{CTRL_RESET, MPIO_RESET, TIMA_RESET,
		TIMB_RESET, IMSK_RESET, VEND_RESET, SUBV_RESET};

	typedef struct packed {
		logic [9:0] addr;
		logic [3:0] width;
	} ecl_req_t;

	typedef struct packed {
		logic [15:0] data;
		logic [3:0]  width;
		logic        fail;
	} ecl_rsp_t;

endpackage : ecl_pkg
